/* File: ssbsr_pkg.sv */
/*
  Constants for the status byte summary block: bit positions, widths, weights.
  Assumes nothing of its surroundings.
*/
package ssbsr_pkg;
  localparam int unsigned SB_W = 8;
  localparam int unsigned EV_W = 16;
  localparam int unsigned NGRP = 5;
  localparam int unsigned BIT_HW1 = 0;
  localparam int unsigned BIT_HW2 = 1;
  localparam int unsigned BIT_UNUSED = 2;
  localparam int unsigned BIT_QUES = 3;
  localparam int unsigned BIT_MAV = 4;
  localparam int unsigned BIT_ESB = 5;
  localparam int unsigned BIT_RQS = 6;
  localparam int unsigned BIT_OPER = 7;
  localparam int unsigned GRP_HW1 = 0;
  localparam int unsigned GRP_HW2 = 1;
  localparam int unsigned GRP_QUES = 2;
  localparam int unsigned GRP_ESB = 3;
  localparam int unsigned GRP_OPER = 4;
  localparam logic [SB_W-1:0] SB_RST = 8'h00;
  localparam logic [SB_W-1:0] SRE_RST = 8'h00;
  localparam logic [EV_W-1:0] EV_RST = 16'h0000;
  localparam logic [SB_W-1:0] RQS_MASK = 8'h40;
  localparam logic [SB_W-1:0] NOT_RQS_MASK = 8'hbf;
  typedef enum logic [2:0] {
    SSBSR_IDLE = 3'b001,
    SSBSR_REQ = 3'b010,
    SSBSR_POLLED = 3'b100
  } ssbsr_srq_t;
endpackage

/* File: ssbsr_grp_if.sv */
/*
  Interface carrying one status group's event, enable and summary signals.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface ssbsr_grp_if;
  logic [ssbsr_pkg::EV_W-1:0] set_bits;
  logic [ssbsr_pkg::EV_W-1:0] enable;
  logic query;
  logic clear_all;
  logic [ssbsr_pkg::EV_W-1:0] event_bits;
  logic summary;
  modport owner (input set_bits, enable, query, clear_all, output event_bits, summary);
  modport user (output set_bits, enable, query, clear_all, input event_bits, summary);
endinterface

/* File: ssbsr_event_group.sv */
/*
  One status group event register with its enable mask and summary message.
  Assumes set, query and clear are synchronous to i_ref_clk.
*/
`timescale 1ns/1ps
module ssbsr_event_group (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ssbsr_grp_if.owner grp
);
  logic [ssbsr_pkg::EV_W-1:0] event_r;
  logic [ssbsr_pkg::EV_W-1:0] event_nxt;
  logic [ssbsr_pkg::EV_W-1:0] kept;

  // ----------------------------------------------------------------
  // Latch events; a new event in the clearing cycle survives
  // ----------------------------------------------------------------
  assign kept = (grp.query || grp.clear_all) ? ssbsr_pkg::EV_RST : event_r;
  assign event_nxt = kept | grp.set_bits;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      event_r <= ssbsr_pkg::EV_RST;
    end else begin
      event_r <= event_nxt;
    end
  end

  assign grp.event_bits = event_r;
  assign grp.summary = |(event_r & grp.enable);

  a_latch_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!grp.query && !grp.clear_all) |=> ((event_r & $past(event_r)) == $past(event_r)))
    else $error("event bit lost without query or clear");
  a_clear_empties: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (grp.clear_all && grp.set_bits == ssbsr_pkg::EV_RST) |=> event_r == ssbsr_pkg::EV_RST)
    else $error("clear left event bits set");
endmodule

/* File: ssbsr_status_byte.sv */
/*
  Status byte summary and service request logic.
  Assumes serial poll, query and clear strobes are one-cycle pulses on i_ref_clk,
  and that the output queue level and the set, enable and query inputs of all five
  event groups are supplied from outside.
*/
`timescale 1ns/1ps

// What this block does
// - Keep an 8-bit status byte of group summaries plus a service request bit.
// - Each mapped bit follows its group summary continuously.
// - Bit 7 carries the operation group summary.
// - Bit 5 carries the standard event summary.
// - Bit 4 is message available, set while the output queue holds data.
// - Bit 3 questionable, bit 1 hardware two, bit 0 hardware one.
// - The hardware one group may reach the byte through a mapped operation event bit.
// - In a serial poll bit 6 shows whether service is being requested.
// - A serial poll clears the request bit.
// - A serial poll leaves the other seven bits unchanged.
// - In a query bit 6 is OR of byte and enable mask, bit 6 excluded.
// - A query changes no status byte bit.
// - Query answer is a value 0 to 251 from the bit weights, bit 2 always zero.
// - Master summary weighs 64, others their binary weights.
// - The status byte is read-only and ignores writes.
// - Clear-status empties the event registers, keeping only bits set in that cycle, such as nested operation bits.
// - Clear-status leaves the output queue and message available bit alone.
// - A rising master summary raises the service request and sets the request bit; a further enabled condition while it stays high does not.
// - A group summary is OR of event bits ANDed with enable bits.
// - Event bits stay set until queried or cleared.
module ssbsr_status_byte (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_hw1_set,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_hw1_enable,
  input wire logic i_hw1_query,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_hw2_set,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_hw2_enable,
  input wire logic i_hw2_query,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_ques_set,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_ques_enable,
  input wire logic i_ques_query,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_esb_set,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_esb_enable,
  input wire logic i_esb_query,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_oper_set,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_oper_enable,
  input wire logic i_oper_query,
  input wire logic [ssbsr_pkg::EV_W-1:0] i_nest_map,
  input wire logic i_out_queue_nonempty,
  input wire logic i_clear_status,
  input wire logic [ssbsr_pkg::SB_W-1:0] i_srq_enable,
  input wire logic i_srq_enable_wr,
  input wire logic i_serial_poll,
  input wire logic i_stb_query,
  input wire logic i_status_byte_wr,
  input wire logic [ssbsr_pkg::SB_W-1:0] i_status_byte_wdata,
  output logic o_srq,
  output logic [ssbsr_pkg::SB_W-1:0] o_poll_byte,
  output logic o_poll_valid,
  output logic [ssbsr_pkg::SB_W-1:0] o_query_value,
  output logic o_query_valid,
  output logic [ssbsr_pkg::SB_W-1:0] o_status_byte,
  output logic [ssbsr_pkg::SB_W-1:0] o_srq_enable,
  output logic o_mss
);
  // ----------------------------------------------------------------
  // Status groups
  // ----------------------------------------------------------------
  ssbsr_grp_if grp_bus [ssbsr_pkg::NGRP] ();
  logic [ssbsr_pkg::NGRP-1:0] summ;
  logic [ssbsr_pkg::EV_W-1:0] set_in [ssbsr_pkg::NGRP];
  logic [ssbsr_pkg::EV_W-1:0] en_in [ssbsr_pkg::NGRP];
  logic [ssbsr_pkg::NGRP-1:0] qry_in;
  logic [ssbsr_pkg::EV_W-1:0] nest_bits;

  // The nested summary of the hardware one group feeds mapped operation event bits
  assign nest_bits = i_nest_map & {ssbsr_pkg::EV_W{summ[ssbsr_pkg::GRP_HW1]}};

  assign set_in[ssbsr_pkg::GRP_HW1] = i_hw1_set;
  assign set_in[ssbsr_pkg::GRP_HW2] = i_hw2_set;
  assign set_in[ssbsr_pkg::GRP_QUES] = i_ques_set;
  assign set_in[ssbsr_pkg::GRP_ESB] = i_esb_set;
  assign set_in[ssbsr_pkg::GRP_OPER] = i_oper_set | nest_bits;
  assign en_in[ssbsr_pkg::GRP_HW1] = i_hw1_enable;
  assign en_in[ssbsr_pkg::GRP_HW2] = i_hw2_enable;
  assign en_in[ssbsr_pkg::GRP_QUES] = i_ques_enable;
  assign en_in[ssbsr_pkg::GRP_ESB] = i_esb_enable;
  assign en_in[ssbsr_pkg::GRP_OPER] = i_oper_enable;
  assign qry_in = {i_oper_query, i_esb_query, i_ques_query, i_hw2_query, i_hw1_query};

  genvar g;
  generate
    for (g = 0; g < ssbsr_pkg::NGRP; g++) begin : gen_grp
      assign grp_bus[g].set_bits = set_in[g];
      assign grp_bus[g].enable = en_in[g];
      assign grp_bus[g].query = qry_in[g];
      assign grp_bus[g].clear_all = i_clear_status;
      assign summ[g] = grp_bus[g].summary;
      ssbsr_event_group u_grp (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .grp(grp_bus[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status byte assembly
  // ----------------------------------------------------------------
  function automatic logic [ssbsr_pkg::SB_W-1:0] with_bit6(
    input logic [ssbsr_pkg::SB_W-1:0] sb,
    input logic b6
  );
    with_bit6 = (sb & ssbsr_pkg::NOT_RQS_MASK) | (b6 ? ssbsr_pkg::RQS_MASK : ssbsr_pkg::SB_RST);
  endfunction

  logic [ssbsr_pkg::SB_W-1:0] sb_sum;
  logic [ssbsr_pkg::SB_W-1:0] sre_r;
  logic [ssbsr_pkg::SB_W-1:0] sre_nxt;
  logic mss;

  // Bit 6 is zero here; it is filled per read method
  assign sb_sum[ssbsr_pkg::BIT_HW1] = summ[ssbsr_pkg::GRP_HW1];
  assign sb_sum[ssbsr_pkg::BIT_HW2] = summ[ssbsr_pkg::GRP_HW2];
  assign sb_sum[ssbsr_pkg::BIT_UNUSED] = 1'b0;
  assign sb_sum[ssbsr_pkg::BIT_QUES] = summ[ssbsr_pkg::GRP_QUES];
  assign sb_sum[ssbsr_pkg::BIT_MAV] = i_out_queue_nonempty;
  assign sb_sum[ssbsr_pkg::BIT_ESB] = summ[ssbsr_pkg::GRP_ESB];
  assign sb_sum[ssbsr_pkg::BIT_RQS] = 1'b0;
  assign sb_sum[ssbsr_pkg::BIT_OPER] = summ[ssbsr_pkg::GRP_OPER];

  // Writes to the status byte have no path into any state
  logic unused_wr;
  assign unused_wr = i_status_byte_wr & (|i_status_byte_wdata);

  assign mss = |(sb_sum & sre_r & ssbsr_pkg::NOT_RQS_MASK);
  assign sre_nxt = i_srq_enable_wr ? (i_srq_enable & ssbsr_pkg::NOT_RQS_MASK) : sre_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sre_r <= ssbsr_pkg::SRE_RST;
    end else begin
      sre_r <= sre_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Service request sequencing
  // ----------------------------------------------------------------
  ssbsr_pkg::ssbsr_srq_t st_r;
  ssbsr_pkg::ssbsr_srq_t st_nxt;
  logic mss_r;
  logic new_reason;

  // A new reason is a rising master summary
  assign new_reason = mss & ~mss_r;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ssbsr_pkg::SSBSR_IDLE: begin
        if (new_reason) begin
          st_nxt = ssbsr_pkg::SSBSR_REQ;
        end
      end
      ssbsr_pkg::SSBSR_REQ: begin
        if (i_serial_poll) begin
          st_nxt = ssbsr_pkg::SSBSR_POLLED;
        end
      end
      ssbsr_pkg::SSBSR_POLLED: begin
        if (new_reason) begin
          st_nxt = ssbsr_pkg::SSBSR_REQ;
        end else if (!mss) begin
          st_nxt = ssbsr_pkg::SSBSR_IDLE;
        end
      end
      default: begin
        st_nxt = ssbsr_pkg::SSBSR_IDLE;
      end
    endcase
  end

  logic rqs;
  assign rqs = (st_r == ssbsr_pkg::SSBSR_REQ);
  assign o_srq = rqs;

  logic [ssbsr_pkg::SB_W-1:0] poll_r;
  logic [ssbsr_pkg::SB_W-1:0] qry_r;
  logic poll_v_r;
  logic qry_v_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r <= ssbsr_pkg::SSBSR_IDLE;
      mss_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mss_r <= mss;
    end
  end

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      poll_r <= ssbsr_pkg::SB_RST;
      qry_r <= ssbsr_pkg::SB_RST;
      poll_v_r <= 1'b0;
      qry_v_r <= 1'b0;
    end else begin
      poll_v_r <= i_serial_poll;
      qry_v_r <= i_stb_query;
      if (i_serial_poll) begin
        poll_r <= with_bit6(sb_sum, rqs);
      end
      if (i_stb_query) begin
        qry_r <= with_bit6(sb_sum, mss);
      end
    end
  end

  assign o_poll_byte = poll_r;
  assign o_poll_valid = poll_v_r;
  assign o_query_value = qry_r;
  assign o_query_valid = qry_v_r;
  assign o_status_byte = sb_sum;
  assign o_srq_enable = sre_r;
  assign o_mss = mss;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_poll_clears_rqs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_serial_poll && rqs && !new_reason) |=> !o_srq)
    else $error("serial poll did not clear request");
  a_poll_bit6: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_serial_poll |=> o_poll_byte[ssbsr_pkg::BIT_RQS] == $past(o_srq))
    else $error("poll bit 6 not request state");
  a_poll_others: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_serial_poll |=> (o_poll_byte & ssbsr_pkg::NOT_RQS_MASK) == $past(o_status_byte))
    else $error("poll bits differ from status byte");
  a_query_mss: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_stb_query |=> o_query_value[ssbsr_pkg::BIT_RQS] ==
      |($past(o_status_byte) & $past(sre_r) & ssbsr_pkg::NOT_RQS_MASK))
    else $error("query bit 6 not master summary");
  a_query_no_change: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_stb_query && !i_serial_poll && st_r == st_nxt) |=> $stable(st_r))
    else $error("query altered request state");
  a_unused_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_status_byte[ssbsr_pkg::BIT_UNUSED] && !o_status_byte[ssbsr_pkg::BIT_RQS])
    else $error("unused bit set");
  a_mav_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_status_byte[ssbsr_pkg::BIT_MAV] == i_out_queue_nonempty)
    else $error("message available wrong");
  a_clear_drops: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clear_status && i_hw1_set == ssbsr_pkg::EV_RST && i_esb_set == ssbsr_pkg::EV_RST)
      |=> !o_status_byte[ssbsr_pkg::BIT_HW1] && !o_status_byte[ssbsr_pkg::BIT_ESB])
    else $error("clear left summary set");
  a_srq_raise: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (new_reason && !o_srq) |=> o_srq)
    else $error("request not raised on new reason");
  a_srq_needs_reason: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!o_srq && !new_reason) |=> !o_srq)
    else $error("request raised without new reason");
  a_write_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_status_byte_wr && $stable(sb_sum)) |=> $stable(st_r) || $past(new_reason || i_serial_poll
      || !mss))
    else $error("write changed state");
  a_byte_oper: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_status_byte[ssbsr_pkg::BIT_OPER] ==
      |(grp_bus[ssbsr_pkg::GRP_OPER].event_bits & i_oper_enable))
    else $error("operation summary bit wrong");
  a_byte_esb: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_status_byte[ssbsr_pkg::BIT_ESB] ==
      |(grp_bus[ssbsr_pkg::GRP_ESB].event_bits & i_esb_enable))
    else $error("standard event summary bit wrong");
  a_byte_ques: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_status_byte[ssbsr_pkg::BIT_QUES] ==
      |(grp_bus[ssbsr_pkg::GRP_QUES].event_bits & i_ques_enable))
    else $error("questionable summary bit wrong");
  a_byte_hw: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_status_byte[ssbsr_pkg::BIT_HW1] ==
      |(grp_bus[ssbsr_pkg::GRP_HW1].event_bits & i_hw1_enable)) &&
    (o_status_byte[ssbsr_pkg::BIT_HW2] ==
      |(grp_bus[ssbsr_pkg::GRP_HW2].event_bits & i_hw2_enable)))
    else $error("hardware summary bit wrong");
  a_query_value: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_stb_query |=> (o_query_value & ssbsr_pkg::NOT_RQS_MASK) == $past(o_status_byte))
    else $error("query bits differ from status byte");
  a_poll_answer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_serial_poll |=> o_poll_valid)
    else $error("poll answer missing");
  a_query_answer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_stb_query |=> o_query_valid)
    else $error("query answer missing");
  a_mss_formula: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_mss == |(o_status_byte & o_srq_enable))
    else $error("master summary wrong");

  c_srq_poll: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_srq ##1 i_serial_poll ##1 !o_srq);
  c_query_mss: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_query_valid && o_query_value[ssbsr_pkg::BIT_RQS]);
  c_clear: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_clear_status && o_status_byte[ssbsr_pkg::BIT_ESB]);
  c_rerequest: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    st_r == ssbsr_pkg::SSBSR_POLLED ##1 o_srq);
  c_nest: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    (summ[ssbsr_pkg::GRP_HW1] && i_nest_map != ssbsr_pkg::EV_RST) ##1 o_status_byte[ssbsr_pkg::BIT_OPER]);
endmodule

/* File: ssbsr_ctrl_model.sv */
/*
  Model of the active bus controller: answers a service request with a serial
  poll, then queries every group flagged in the poll byte.
  Assumes the block's poll and query inputs take one-cycle pulses on i_ref_clk.
*/
`timescale 1ns/1ps
module ssbsr_ctrl_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_arm,
  input wire logic i_srq,
  input wire logic i_poll_valid,
  input wire logic [7:0] i_poll_byte,
  output logic o_serial_poll,
  output logic [4:0] o_grp_query
);
  logic busy_r;
  wire logic [4:0] flagged;
  // Group order hw1, hw2, questionable, standard event, operation
  assign flagged = {i_poll_byte[7], i_poll_byte[5], i_poll_byte[3],
    i_poll_byte[1], i_poll_byte[0]};
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      busy_r <= 1'b0;
      o_serial_poll <= 1'b0;
      o_grp_query <= 5'h00;
    end else begin
      o_serial_poll <= i_arm && i_srq && !busy_r && !o_serial_poll;
      busy_r <= (busy_r || o_serial_poll) && !i_poll_valid;
      o_grp_query <= (i_arm && busy_r && i_poll_valid) ? flagged : 5'h00;
    end
  end
endmodule

/* File: tb_status_byte_service_request.sv */
/*
  Self-checking bench for the status byte and service request block.
  Assumes the controller model file is compiled before it.
*/
`timescale 1ns/1ps
module tb_status_byte_service_request;
  logic clk, rst, mav_r, cls_r, sre_wr_r, poll_r, stbq_r, sbwr_r, arm_r;
  logic [15:0] set_v [5];
  logic [15:0] en_v [5];
  logic [15:0] nest_r;
  logic [4:0] qry_r;
  logic [7:0] sre_r;
  logic srq, poll_valid, qvalid, mss, m_poll;
  logic [7:0] poll_byte, qval, sbyte, sre_q;
  logic [4:0] m_qry;
  wire logic [4:0] qry_all = qry_r | m_qry;
  int n_errors = 0;
  int n_compared = 0;
  logic [7:0] wt [5] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h80};

  ssbsr_status_byte ssbsr_status_byte_i (
    .i_ref_clk(clk), .i_rst(rst),
    .i_hw1_set(set_v[0]), .i_hw1_enable(en_v[0]), .i_hw1_query(qry_all[0]),
    .i_hw2_set(set_v[1]), .i_hw2_enable(en_v[1]), .i_hw2_query(qry_all[1]),
    .i_ques_set(set_v[2]), .i_ques_enable(en_v[2]), .i_ques_query(qry_all[2]),
    .i_esb_set(set_v[3]), .i_esb_enable(en_v[3]), .i_esb_query(qry_all[3]),
    .i_oper_set(set_v[4]), .i_oper_enable(en_v[4]), .i_oper_query(qry_all[4]),
    .i_nest_map(nest_r), .i_out_queue_nonempty(mav_r), .i_clear_status(cls_r),
    .i_srq_enable(sre_r), .i_srq_enable_wr(sre_wr_r), .i_serial_poll(poll_r | m_poll),
    .i_stb_query(stbq_r), .i_status_byte_wr(sbwr_r), .i_status_byte_wdata(8'hff),
    .o_srq(srq), .o_poll_byte(poll_byte), .o_poll_valid(poll_valid),
    .o_query_value(qval), .o_query_valid(qvalid), .o_status_byte(sbyte),
    .o_srq_enable(sre_q), .o_mss(mss)
  );

  ssbsr_ctrl_model ssbsr_ctrl_model_i (
    .i_ref_clk(clk), .i_rst(rst), .i_arm(arm_r), .i_srq(srq),
    .i_poll_valid(poll_valid), .i_poll_byte(poll_byte),
    .o_serial_poll(m_poll), .o_grp_query(m_qry)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for poll valid (0), query valid (1) or service request (2)
  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 16; i++) begin
      #1;
      if ((sel == 0 && poll_valid === 1'b1) || (sel == 1 && qvalid === 1'b1)
          || (sel == 2 && srq === 1'b1)) begin
        break;
      end
      @(posedge clk);
    end
    if (i == 16) begin
      chk(8'h00, 8'h01);
      tally_and_finish();
    end
  endtask

  task automatic poll(input logic [7:0] exp);
    @(posedge clk);
    poll_r <= 1'b1;
    @(posedge clk);
    poll_r <= 1'b0;
    wait_for(0);
    chk(poll_byte, exp);
  endtask

  task automatic query(input logic [7:0] exp);
    @(posedge clk);
    stbq_r <= 1'b1;
    @(posedge clk);
    stbq_r <= 1'b0;
    wait_for(1);
    chk(qval, exp);
  endtask

  task automatic set_grp(input int g, input logic [15:0] bits);
    @(posedge clk);
    set_v[g] <= bits;
    @(posedge clk);
    set_v[g] <= 16'h0000;
    #1;
  endtask

  task automatic clr_grp(input int g);
    @(posedge clk);
    qry_r[g] <= 1'b1;
    @(posedge clk);
    qry_r[g] <= 1'b0;
    #1;
  endtask

  task automatic write_sre(input logic [7:0] v);
    @(posedge clk);
    sre_r <= v;
    sre_wr_r <= 1'b1;
    @(posedge clk);
    sre_wr_r <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {mav_r, cls_r, sre_wr_r, poll_r, stbq_r, sbwr_r, arm_r} = 7'h00;
    nest_r = 16'h0000;
    qry_r = 5'h00;
    sre_r = 8'h00;
    for (int g = 0; g < 5; g++) begin
      set_v[g] = 16'h0000;
      en_v[g] = 16'hffff;
    end
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(sbyte, 8'h00);
    for (int g = 0; g < 5; g++) begin
      set_grp(g, 16'h0001 << g);
      chk(sbyte, wt[g]);
      repeat (3) @(posedge clk);
      #1;
      chk(sbyte, wt[g]);
      query(wt[g]);
      clr_grp(g);
      chk(sbyte, 8'h00);
    end
    $display("group mapping test done");
    @(posedge clk);
    mav_r <= 1'b1;
    sbwr_r <= 1'b1;
    @(posedge clk);
    sbwr_r <= 1'b0;
    #1;
    chk(sbyte, 8'h10);
    @(posedge clk);
    en_v[2] <= 16'h0000;
    set_grp(2, 16'h8000);
    chk(sbyte, 8'h10);
    @(posedge clk);
    en_v[2] <= 16'hffff;
    #1;
    chk(sbyte, 8'h18);
    clr_grp(2);
    $display("enable and write test done");
    write_sre(8'h60);
    chk(sre_q, 8'h20);
    set_grp(3, 16'h0004);
    wait_for(2);
    chk({7'h00, mss}, 8'h01);
    query(8'h70);
    chk({7'h00, srq}, 8'h01);
    poll(8'h70);
    chk({7'h00, srq}, 8'h00);
    poll(8'h30);
    query(8'h70);
    @(posedge clk);
    cls_r <= 1'b1;
    @(posedge clk);
    cls_r <= 1'b0;
    #1;
    chk(sbyte, 8'h10);
    chk({7'h00, mss}, 8'h00);
    $display("service request test done");
    @(posedge clk);
    nest_r <= 16'h0001;
    set_grp(0, 16'h0001);
    @(posedge clk);
    #1;
    chk(sbyte, 8'h91);
    @(posedge clk);
    nest_r <= 16'h0000;
    clr_grp(0);
    clr_grp(4);
    chk(sbyte, 8'h10);
    $display("nesting test done");
    @(posedge clk);
    arm_r <= 1'b1;
    write_sre(8'h01);
    set_grp(0, 16'h0002);
    wait_for(2);
    repeat (8) @(posedge clk);
    #1;
    chk(sbyte, 8'h10);
    chk({7'h00, srq}, 8'h00);
    chk(poll_byte, 8'h51);
    chk({7'h00, mss}, 8'h00);
    $display("controller test done");
    tally_and_finish();
  end
endmodule
